// ===== core/bpt_params.svh
// constants of the bit error rate pattern tester: offsets, fields, reset values, counts
`ifndef BPT_PARAMS_SVH
`define BPT_PARAMS_SVH

`define BPT_ADDR_W 8
`define BPT_DATA_W 32

`define BPT_OFS_CFG 8'h00
`define BPT_OFS_DUR 8'h04
`define BPT_OFS_CMD 8'h08
`define BPT_OFS_STAT 8'h0C
`define BPT_OFS_ELAPSED 8'h10
`define BPT_OFS_ERRSEC 8'h14
`define BPT_OFS_BLOCKS 8'h18
`define BPT_OFS_BLKERR 8'h1C
`define BPT_OFS_BITS_LO 8'h20
`define BPT_OFS_BITS_HI 8'h24
`define BPT_OFS_BITERR 8'h28

`define BPT_CMD_START 0
`define BPT_CMD_ABORT 1
`define BPT_CMD_INJECT 2

`define BPT_CFG_RST 8'h00
`define BPT_DUR_RST 32'h000F4240

`define BPT_BLK_FIXED 12'd1000
`define BPT_BIT_MAX 37'd99000000000
`define BPT_LFSR_SEED 12'hFFF
`define BPT_CHAR_MIN 4'd5

`endif

// ===== core/bpt_pkg.sv
// types of the bit error rate pattern tester
package bpt_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bpt_bus_req_t;

  typedef struct packed {
    logic par_odd;
    logic par_en;
    logic [1:0] char_sel;
    logic frame_en;
    logic blk_pat;
    logic [1:0] pat_sel;
  } bpt_cfg_t;

  typedef enum logic [2:0] {
    BPT_TX_OFF = 3'b000,
    BPT_TX_START = 3'b001,
    BPT_TX_DATA = 3'b011,
    BPT_TX_PAR = 3'b010,
    BPT_TX_STOP = 3'b110,
    BPT_TX_GAP = 3'b111
  } bpt_tx_st_t;

  typedef enum logic [1:0] {
    BPT_RX_HUNT = 2'b00,
    BPT_RX_DATA = 2'b01,
    BPT_RX_SKIP = 2'b11
  } bpt_rx_st_t;

  typedef struct packed {
    logic [15:0] elapsed;
    logic [15:0] errsec;
    logic [15:0] blocks;
    logic [15:0] blkerr;
    logic [36:0] bits;
    logic [15:0] biterr;
  } bpt_cnt_t;

  typedef struct packed {
    bpt_cfg_t cfg;
    logic [31:0] duration;
    bpt_tx_st_t tx_st;
    logic [11:0] tx_lfsr;
    logic [3:0] tx_cnt;
    logic tx_par;
    logic tx_bit;
    logic inj_pend;
    logic tx_run;
    bpt_rx_st_t rx_st;
    logic [3:0] rx_cnt;
    logic [11:0] rx_ref;
    logic [3:0] seed_cnt;
    logic synced;
    logic rx_run;
    logic [11:0] blk_pos;
    logic blk_bad;
    logic sec_bad;
    bpt_cnt_t cnt;
    logic [5:0] roll;
    logic [31:0] rdata;
  } bpt_state_t;

endpackage : bpt_pkg

// ===== core/bpt_top.sv
// bit error rate pattern tester: generator, framer, receiver checker and result counters
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "bpt_params.svh"

module bpt_top (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic bit_en_i,
  input wire logic sec_tick_i,
  input wire logic rx_bit_i,
  input wire bpt_pkg::bpt_bus_req_t bus_i,
  output logic [31:0] rdata_o,
  output logic tx_bit_o,
  output logic tx_active_o,
  output logic rx_active_o,
  output logic synced_o
);
  import bpt_pkg::*;

  bpt_state_t s;
  bpt_state_t next_s;

  // feedback of the selected maximal-length polynomial
  function automatic logic lfsr_fb(input logic [1:0] sel, input logic [11:0] r);
    logic fb;
    fb = 1'b0;
    unique case (sel)
      2'd0: fb = r[5] ^ r[4];                  // x^6+x^5+1
      2'd1: fb = r[8] ^ r[4];                  // x^9+x^5+1
      2'd2: fb = r[10] ^ r[8];                 // x^11+x^9+1
      2'd3: fb = r[11] ^ r[10] ^ r[9] ^ r[3];  // x^12+x^11+x^10+x^4+1
    endcase
    return fb;
  endfunction : lfsr_fb

  function automatic logic [3:0] lfsr_len(input logic [1:0] sel);
    logic [3:0] len;
    len = 4'd6;
    unique case (sel)
      2'd0: len = 4'd6;
      2'd1: len = 4'd9;
      2'd2: len = 4'd11;
      2'd3: len = 4'd12;
    endcase
    return len;
  endfunction : lfsr_len

  // carry out in the top bit marks the wrap to zero
  function automatic logic [16:0] inc16(input logic [15:0] v);
    return {1'b0, v} + 17'h00001;
  endfunction : inc16

  logic [3:0] char_w;
  logic [3:0] frame_len;
  logic [3:0] reg_len;
  logic [11:0] blk_size;
  logic tx_fb;
  logic tx_pat;
  logic rx_fb;
  logic rx_strobe;
  logic rx_err;
  logic [5:0] roll_ev;
  logic [16:0] sum16;
  logic [36:0] bits_new;
  logic start_cmd;
  logic abort_cmd;
  logic inject_cmd;
  logic cmd_wr;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  // decode and derived sizes, shared by the state update and the read mux
  always_comb begin
    char_w = `BPT_CHAR_MIN + {2'b00, s.cfg.char_sel};
    frame_len = 4'd3 + char_w + {3'b000, s.cfg.par_en};
    reg_len = lfsr_len(s.cfg.pat_sel);
    blk_size = s.cfg.blk_pat ? ((12'h001 << reg_len) - 12'h001) : `BPT_BLK_FIXED;
    tx_fb = lfsr_fb(s.cfg.pat_sel, s.tx_lfsr);
    tx_pat = tx_fb ^ s.inj_pend;
    rx_fb = lfsr_fb(s.cfg.pat_sel, s.rx_ref);
    cmd_wr = bus_i.wr && (bus_i.addr == `BPT_OFS_CMD);
    start_cmd = cmd_wr && bus_i.wdata[`BPT_CMD_START];
    abort_cmd = cmd_wr && bus_i.wdata[`BPT_CMD_ABORT];
    inject_cmd = cmd_wr && bus_i.wdata[`BPT_CMD_INJECT];
    // status word: run, sync and inject state low, sticky rollover flags above
    stat_word = 32'h00000000;
    stat_word[0] = s.tx_run;
    stat_word[1] = s.rx_run;
    stat_word[2] = s.synced;
    stat_word[3] = s.inj_pend;
    stat_word[9:4] = s.roll;
  end

  // live read mux from the current state: a read never stalls the
  always_comb begin
    rd_word = 32'h00000000;
    unique case (bus_i.addr)
      `BPT_OFS_CFG: rd_word = {24'h000000, s.cfg};
      `BPT_OFS_DUR: rd_word = s.duration;
      `BPT_OFS_STAT: rd_word = stat_word;
      `BPT_OFS_ELAPSED: rd_word = {16'h0000, s.cnt.elapsed};
      `BPT_OFS_ERRSEC: rd_word = {16'h0000, s.cnt.errsec};
      `BPT_OFS_BLOCKS: rd_word = {16'h0000, s.cnt.blocks};
      `BPT_OFS_BLKERR: rd_word = {16'h0000, s.cnt.blkerr};
      `BPT_OFS_BITS_LO: rd_word = s.cnt.bits[31:0];
      `BPT_OFS_BITS_HI: rd_word = {27'h0000000, s.cnt.bits[36:32]};
      `BPT_OFS_BITERR: rd_word = {16'h0000, s.cnt.biterr};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_comb begin
    next_s = s;
    rx_strobe = 1'b0;
    rx_err = 1'b0;
    roll_ev = 6'h00;
    sum16 = 17'h00000;
    bits_new = s.cnt.bits;

    // transmitter: runs on until an abort, independent of the receiver
    if (s.tx_run && bit_en_i) begin
      if (!s.cfg.frame_en) begin
        next_s.tx_bit = tx_pat;
        next_s.tx_lfsr = {s.tx_lfsr[10:0], tx_fb};
        next_s.inj_pend = 1'b0;
      end else begin
        unique case (s.tx_st)
          BPT_TX_START: begin
            next_s.tx_bit = 1'b0;
            next_s.tx_cnt = 4'h0;
            next_s.tx_par = s.cfg.par_odd;
            next_s.tx_st = BPT_TX_DATA;
          end
          BPT_TX_DATA: begin
            next_s.tx_bit = tx_pat;
            next_s.tx_lfsr = {s.tx_lfsr[10:0], tx_fb};
            next_s.inj_pend = 1'b0;
            // parity covers the bits really sent, an injected error included
            next_s.tx_par = s.tx_par ^ tx_pat;
            if (s.tx_cnt == char_w - 4'h1) begin
              next_s.tx_cnt = 4'h0;
              next_s.tx_st = s.cfg.par_en ? BPT_TX_PAR : BPT_TX_STOP;
            end else begin
              next_s.tx_cnt = s.tx_cnt + 4'h1;
            end
          end
          BPT_TX_PAR: begin
            next_s.tx_bit = s.tx_par;
            next_s.tx_st = BPT_TX_STOP;
          end
          BPT_TX_STOP: begin
            next_s.tx_bit = 1'b1;
            if (s.tx_cnt == 4'h1) begin
              next_s.tx_cnt = 4'h0;
              next_s.tx_st = BPT_TX_GAP;
            end else begin
              next_s.tx_cnt = s.tx_cnt + 4'h1;
            end
          end
          BPT_TX_GAP: begin
            // idle high for exactly one frame length
            next_s.tx_bit = 1'b1;
            if (s.tx_cnt == frame_len - 4'h1) begin
              next_s.tx_cnt = 4'h0;
              next_s.tx_st = BPT_TX_START;
            end else begin
              next_s.tx_cnt = s.tx_cnt + 4'h1;
            end
          end
          default: begin
            next_s.tx_bit = 1'b1;
            next_s.tx_st = BPT_TX_START;
          end
        endcase
      end
    end

    // receiver framing: only data bits reach the checker
    if (s.rx_run && bit_en_i) begin
      if (!s.cfg.frame_en) begin
        rx_strobe = 1'b1;
      end else begin
        unique case (s.rx_st)
          BPT_RX_HUNT: begin
            // bit pacing must line up with the incoming bits: there is no oversampling
            if (!rx_bit_i) begin
              next_s.rx_cnt = 4'h0;
              next_s.rx_st = BPT_RX_DATA;
            end
          end
          BPT_RX_DATA: begin
            rx_strobe = 1'b1;
            if (s.rx_cnt == char_w - 4'h1) begin
              next_s.rx_cnt = 4'h0;
              next_s.rx_st = BPT_RX_SKIP;
            end else begin
              next_s.rx_cnt = s.rx_cnt + 4'h1;
            end
          end
          BPT_RX_SKIP: begin
            // parity and both stops are stepped over before hunting again
            if (s.rx_cnt == {3'b000, s.cfg.par_en} + 4'h1) begin
              next_s.rx_st = BPT_RX_HUNT;
            end else begin
              next_s.rx_cnt = s.rx_cnt + 4'h1;
            end
          end
          default: next_s.rx_st = BPT_RX_HUNT;
        endcase
      end
    end

    // checker: seed the reference, then compare bit by bit
    if (rx_strobe) begin
      if (!s.synced) begin
        next_s.rx_ref = {s.rx_ref[10:0], rx_bit_i};
        next_s.seed_cnt = s.seed_cnt + 4'h1;
        if (s.seed_cnt == reg_len - 4'h1) begin
          next_s.synced = 1'b1;
        end
      end else begin
        rx_err = rx_bit_i ^ rx_fb;
        // the reference runs free so one bad bit counts once, not L times
        next_s.rx_ref = {s.rx_ref[10:0], rx_fb};
        // the bit count wraps at its own ceiling, not at a power of two
        if (s.cnt.bits == `BPT_BIT_MAX) begin
          bits_new = 37'h0000000000;
          roll_ev[4] = 1'b1;
        end else begin
          bits_new = s.cnt.bits + 37'h0000000001;
        end
        next_s.cnt.bits = bits_new;
        if (rx_err) begin
          sum16 = inc16(s.cnt.biterr);
          next_s.cnt.biterr = sum16[15:0];
          roll_ev[5] = sum16[16];
          next_s.sec_bad = 1'b1;
        end
        if (s.blk_pos == blk_size - 12'h001) begin
          next_s.blk_pos = 12'h000;
          next_s.blk_bad = 1'b0;
          sum16 = inc16(s.cnt.blocks);
          next_s.cnt.blocks = sum16[15:0];
          roll_ev[2] = sum16[16];
          if (s.blk_bad || rx_err) begin
            sum16 = inc16(s.cnt.blkerr);
            next_s.cnt.blkerr = sum16[15:0];
            roll_ev[3] = sum16[16];
          end
        end else begin
          next_s.blk_pos = s.blk_pos + 12'h001;
          next_s.blk_bad = s.blk_bad | rx_err;
        end
        // a zero duration never ends the run
        if ((s.duration != 32'h00000000) && (bits_new == {5'h00, s.duration})) begin
          next_s.rx_run = 1'b0;
        end
      end
    end

    // seconds advance only once the pattern is locked
    if (s.rx_run && s.synced && sec_tick_i) begin
      sum16 = inc16(s.cnt.elapsed);
      next_s.cnt.elapsed = sum16[15:0];
      roll_ev[0] = sum16[16];
      if (s.sec_bad || rx_err) begin
        sum16 = inc16(s.cnt.errsec);
        next_s.cnt.errsec = sum16[15:0];
        roll_ev[1] = sum16[16];
      end
      next_s.sec_bad = 1'b0;
    end

    next_s.roll = s.roll | roll_ev;

    // register writes may land during a run without stalling anything
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        `BPT_OFS_CFG: next_s.cfg = bpt_cfg_t'(bus_i.wdata[7:0]);
        `BPT_OFS_DUR: next_s.duration = bus_i.wdata;
        default: ;
      endcase
    end
    if (inject_cmd && (s.tx_run || start_cmd)) begin
      next_s.inj_pend = 1'b1;
    end
    if (start_cmd) begin
      next_s.tx_run = 1'b1;
      next_s.tx_st = BPT_TX_START;
      next_s.tx_lfsr = `BPT_LFSR_SEED;
      // back to idle, so a looped-back receiver seeds on a bit that fits the all-ones start
      next_s.tx_bit = 1'b1;
      next_s.tx_cnt = 4'h0;
      next_s.rx_run = 1'b1;
      next_s.rx_st = BPT_RX_HUNT;
      next_s.rx_cnt = 4'h0;
      next_s.seed_cnt = 4'h0;
      next_s.synced = 1'b0;
      next_s.blk_pos = 12'h000;
      next_s.blk_bad = 1'b0;
      next_s.sec_bad = 1'b0;
      next_s.cnt = '0;
      // an event in the same cycle still leaves its flag set
      next_s.roll = roll_ev;
    end
    // abort wins over a start in the same write
    if (abort_cmd) begin
      next_s.rx_run = 1'b0;
      next_s.tx_run = 1'b0;
      next_s.tx_st = BPT_TX_OFF;
      next_s.tx_bit = 1'b1;
      next_s.inj_pend = 1'b0;
    end

    // the two bit count halves are not latched together: read them while stopped for a matching pair
    if (bus_i.rd) begin
      next_s.rdata = rd_word;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
      s.cfg <= `BPT_CFG_RST;
      s.duration <= `BPT_DUR_RST;
      s.tx_st <= BPT_TX_OFF;
      s.rx_st <= BPT_RX_HUNT;
      s.tx_lfsr <= `BPT_LFSR_SEED;
      s.tx_bit <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign tx_bit_o = s.tx_bit;
  assign tx_active_o = s.tx_run;
  assign rx_active_o = s.rx_run;
  assign synced_o = s.synced;

endmodule : bpt_top

// ===== testbench/bpt_top_assertions.sv
// port-level checker of the pattern tester
`timescale 1ns/100ps
module bpt_checker (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic bit_en_i,
  input wire logic sec_tick_i,
  input wire logic rx_bit_i,
  input wire bpt_pkg::bpt_bus_req_t bus_i,
  input wire logic [31:0] rdata_o,
  input wire logic tx_bit_o,
  input wire logic tx_active_o,
  input wire logic rx_active_o,
  input wire logic synced_o
);
  import bpt_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic cmd_wr;
  assign cmd_wr = bus_i.wr && bus_i.addr == 8'h08;

  a_idle_line_high: assert property (!tx_active_o && !$past(tx_active_o) |-> tx_bit_o)
    else $error("line not high while transmitter off");
  // a restart may reload the line bit outside the bit pacing
  a_tx_bit_paced: assert property (tx_active_o && $past(tx_active_o) && !$past(bit_en_i) && !$past(cmd_wr)
    |-> $stable(tx_bit_o))
    else $error("line bit moved without a bit enable");
  a_rdata_holds: assert property (!$past(bus_i.rd) |-> $stable(rdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (bus_i.rd && bus_i.addr > 8'h28 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_live: assert property (bus_i.rd && bus_i.addr == 8'h0C
    |=> rdata_o[2:0] == $past({synced_o, rx_active_o, tx_active_o}))
    else $error("status read differs from run state");
  a_sync_kept: assert property ($fell(synced_o) |-> $past(cmd_wr && bus_i.wdata[0]))
    else $error("sync lost without a start");
  a_sync_on_bit: assert property ($rose(synced_o) |-> $past(bit_en_i && rx_active_o))
    else $error("sync gained outside a received bit");
  a_rx_start: assert property ($rose(rx_active_o) |-> $past(cmd_wr && bus_i.wdata[0] && !bus_i.wdata[1]))
    else $error("receiver began without a start");
  a_tx_runs_on: assert property ($fell(tx_active_o) |-> $past(cmd_wr && bus_i.wdata[1]))
    else $error("transmitter stopped without abort");
  a_abort_stops: assert property (cmd_wr && bus_i.wdata[1] |=> !rx_active_o && !tx_active_o)
    else $error("abort did not stop the test");

  c_sync: cover property ($rose(synced_o));
  c_rx_end_tx_on: cover property ($fell(rx_active_o) && tx_active_o);
  c_inject: cover property (cmd_wr && bus_i.wdata[2] && synced_o);
endmodule : bpt_checker

bind bpt_top bpt_checker u_bpt_checker (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bit_en_i(bit_en_i),
  .sec_tick_i(sec_tick_i), .rx_bit_i(rx_bit_i), .bus_i(bus_i), .rdata_o(rdata_o), .tx_bit_o(tx_bit_o),
  .tx_active_o(tx_active_o), .rx_active_o(rx_active_o), .synced_o(synced_o));

// ===== testbench/bpt_line_model.sv
// full-duplex loopback line from the transmit pin back to the receive pin
`timescale 1ns/100ps
module bpt_line_model (
  input wire logic tx_bit_i,
  output logic rx_bit_o
);
  // a clean loop: every fault seen by the receiver comes from the tester's own inject command
  assign rx_bit_o = tx_bit_i;
endmodule : bpt_line_model

// ===== testbench/tb_bpt_top.sv
// self-checking bench of the pattern tester in loopback
`timescale 1ns/100ps
module tb_bpt_top;
  import bpt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic bit_en_i = 1'b0;
  logic sec_tick_i = 1'b0;
  logic rx_bit_i;
  bpt_bus_req_t bus_i = '0;
  logic [31:0] rdata_o;
  logic tx_bit_o;
  logic tx_active_o;
  logic rx_active_o;
  logic synced_o;
  logic [1:0] pace = 2'h0;
  int mismatches = 0;
  int num_checks = 0;
  logic [11:0] lfsr;
  logic [17:0] fr;
  logic b;

  bpt_top u_bpt_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bit_en_i(bit_en_i), .sec_tick_i(sec_tick_i),
    .rx_bit_i(rx_bit_i), .bus_i(bus_i), .rdata_o(rdata_o), .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o),
    .rx_active_o(rx_active_o), .synced_o(synced_o));
  bpt_line_model u_bpt_line_model (.tx_bit_i(tx_bit_o), .rx_bit_o(rx_bit_i));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // one bit time every four clocks leaves room for bus traffic between bits
  always @(posedge clk_sys_i) begin
    pace <= pace + 2'h1;
    bit_en_i <= (pace == 2'h3);
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    mismatches++;
    complete_run();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_i <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus_i <= '0;
    #1 check(rdata_o, exp);
  endtask : rd

  task automatic pulse_sec();
    @(posedge clk_sys_i);
    sec_tick_i <= 1'b1;
    @(posedge clk_sys_i);
    sec_tick_i <= 1'b0;
  endtask : pulse_sec

  task automatic next_bit(output logic v);
    do @(posedge clk_sys_i); while (bit_en_i !== 1'b1);
    #1 v = tx_bit_o;
  endtask : next_bit

  task automatic wait_until(input logic want_sync);
    for (int i = 0; i < 20000; i++) begin
      if (want_sync ? synced_o === 1'b1 : rx_active_o === 1'b0) break;
      @(posedge clk_sys_i);
    end
    check(32'(want_sync ? synced_o : !rx_active_o), 32'h1);
  endtask : wait_until

  function automatic logic step(inout logic [11:0] r, input logic [1:0] s);
    logic n;
    case (s)
      2'h0: n = r[5] ^ r[4];
      2'h1: n = r[8] ^ r[4];
      2'h2: n = r[10] ^ r[8];
      default: n = r[11] ^ r[10] ^ r[9] ^ r[3];
    endcase
    r = {r[10:0], n};
    return n;
  endfunction : step

  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h000F4240);
    wr(8'h0C, 32'hFFFFFFFF);
    wr(8'h3C, 32'h1);
    rd(8'h0C, 32'h0);
    rd(8'h3C, 32'h0);
    check(32'(tx_bit_o), 32'h1);
    wr(8'h04, 32'd1100);
    for (int s = 0; s < 4; s++) begin
      // the shortest pattern also runs with pattern-length blocks
      wr(8'h00, (s == 0) ? 32'h4 : 32'(s));
      wr(8'h08, 32'h1);
      lfsr = 12'hFFF;
      for (int k = 0; k < 16; k++) begin
        next_bit(b);
        check(32'(b), 32'(step(lfsr, 2'(s))));
        if (k == 0) pulse_sec();
      end
      wait_until(1'b1);
      wr(8'h08, 32'h4);
      repeat (40) next_bit(b);
      pulse_sec();
      repeat (10) next_bit(b);
      pulse_sec();
      rd(8'h00, (s == 0) ? 32'h4 : 32'(s));
      wait_until(1'b0);
      check(32'(tx_active_o), 32'h1);
      rd(8'h10, 32'd2);
      rd(8'h14, 32'd1);
      rd(8'h18, (s == 0) ? 32'd17 : 32'd1);
      rd(8'h1C, 32'd1);
      rd(8'h20, 32'd1100);
      rd(8'h24, 32'h0);
      rd(8'h28, 32'd1);
      rd(8'h0C, 32'h5);
    end
    wr(8'h00, 32'h48);
    wr(8'h04, 32'd40);
    wr(8'h08, 32'h1);
    lfsr = 12'hFFF;
    for (int f = 0; f < 2; f++) begin
      fr = 18'h3FFFE;
      for (int k = 1; k < 6; k++) begin
        fr[k] = step(lfsr, 2'h0);
      end
      fr[6] = ^fr[5:1];
      for (int k = 0; k < 18; k++) begin
        next_bit(b);
        check(32'(b), 32'(fr[k]));
      end
    end
    wait_until(1'b0);
    rd(8'h20, 32'd40);
    rd(8'h28, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h08, 32'h3);
    @(posedge clk_sys_i);
    #1 check(32'({tx_active_o, rx_active_o}), 32'h0);
    complete_run();
  end
endmodule : tb_bpt_top
